// [tb/serial_host.sv]
// Model of the microcontroller that writes the block over the framed serial port.
// Assumes the block shifts on sclk rise while frame_enable_n is low.
`timescale 1ns/10ps
module serial_host (
  output logic sclk,
  output logic frame_enable_n,
  output logic serial_in
);
  initial begin
    sclk = 1'b0;
    frame_enable_n = 1'b1;
    serial_in = 1'b0;
  end
  // Sends the low n bits of w, MSB first; n of zero gives a bare load pulse.
  // The serial clock stands still outside frames, as the real host leaves it.
  task automatic send(input int n, input logic [23:0] w);
    frame_enable_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #22.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      #40;
    end
    #100;
    frame_enable_n = 1'b1;
    // The released data line shows the opposite of its last bit, so no stale value helps.
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the synthesizer control block.
// Assumes the serial host model drives the link pins; mclk inputs come from here.
`timescale 1ns/10ps
module tb_top;
  logic mclk;
  logic nrst;
  logic sclk;
  logic frame_enable_n;
  logic serial_in;
  logic divided_vco_pulse;
  logic vco_leads;
  logic ref_leads;
  logic modulus_ctrl;
  synth_cfg_pkg::det_out_t det_q;
  logic [7:0] cfg_q;
  logic [2:0] ref_mode_q;
  logic [12:0] active_ratio_q;
  logic [12:0] pending_ratio_q;
  logic [23:0] a_word_q;
  logic [1:0] out_one_mode_q;
  logic out_one_q;
  logic out_two_q;
  logic out_two_oe_n_q;
  logic [6:0] current_pct_q;
  logic counters_run_q;
  logic bias_on_q;
  logic ref_feedback_on_q;
  logic ref_input_on_q;
  logic r_jam_load_q;
  logic det_init_q;
  logic prescale_div65_q;
  int n_fail = 0;
  int cmp_count = 0;

  serial_host host (.sclk(sclk), .frame_enable_n(frame_enable_n), .serial_in(serial_in));

  synth_config_standby_ctrl i_dut (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .frame_enable_n(frame_enable_n),
    .serial_in(serial_in), .divided_vco_pulse(divided_vco_pulse), .vco_leads(vco_leads),
    .ref_leads(ref_leads), .modulus_ctrl(modulus_ctrl), .det_q(det_q), .cfg_q(cfg_q),
    .ref_mode_q(ref_mode_q), .active_ratio_q(active_ratio_q),
    .pending_ratio_q(pending_ratio_q), .a_word_q(a_word_q), .out_one_mode_q(out_one_mode_q),
    .out_one_q(out_one_q), .out_two_q(out_two_q), .out_two_oe_n_q(out_two_oe_n_q),
    .current_pct_q(current_pct_q), .counters_run_q(counters_run_q), .bias_on_q(bias_on_q),
    .ref_feedback_on_q(ref_feedback_on_q), .ref_input_on_q(ref_input_on_q),
    .r_jam_load_q(r_jam_load_q), .det_init_q(det_init_q), .prescale_div65_q(prescale_div65_q)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Frames settle within four mclk edges; eight leave margin for the output stage.
  task automatic settle;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic frame(input int n, input logic [23:0] w);
    host.send(n, w);
    settle();
  endtask

  // The tests need about 32 us of simulated time; the limit allows about six times that.
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    divided_vco_pulse = 1'b0;
    vco_leads = 1'b0;
    ref_leads = 1'b0;
    modulus_ctrl = 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    check("cfg", 24'h00, cfg_q);
    check("ref_mode", 24'h4, ref_mode_q);
    check("out_one_mode", 24'h0, out_one_mode_q);
    check("out_two_oe_n", 24'h0, out_two_oe_n_q);
    check("out_two", 24'h0, out_two_q);
    check("det", 24'h0e, det_q);
    check("div65", 24'h1, prescale_div65_q);
    modulus_ctrl <= 1'b1;
    settle();
    check("div64", 24'h0, prescale_div65_q);
    frame(16, {8'h00, 3'h7, 13'h1abc});
    check("ref_mode", 24'h7, ref_mode_q);
    check("pending", 24'h1abc, pending_ratio_q);
    check("active", 24'h0, active_ratio_q);
    frame(5, 24'h00001f);
    check("refused", 24'h0, cfg_q);
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        frame(8, {16'h0, 4'h0, c[1:0], p[0], 1'b0});
        check("pct", p ? 24'(25 * (c + 1)) : 24'(70 + 10 * c), current_pct_q);
      end
    end
    check("pending kept", 24'h1abc, pending_ratio_q);
    check("a kept", 24'h0, a_word_q);
    frame(24, 24'hc00000);
    check("a_word", 24'hc00000, a_word_q);
    check("active", 24'h1abc, active_ratio_q);
    check("out_one_mode", 24'h3, out_one_mode_q);
    check("cfg kept", 24'h0e, cfg_q);
    frame(8, 24'h06);
    check("port pct", 24'd80, current_pct_q);
    check("out_one", 24'h1, out_one_q);
    frame(8, 24'h05);
    check("port pct", 24'd80, current_pct_q);
    check("out_one", 24'h0, out_one_q);
    check("out_two_oe_n", 24'h1, out_two_oe_n_q);
    frame(16, {8'h00, 3'h2, 13'h0123});
    check("active", 24'h1abc, active_ratio_q);
    frame(0, 24'h0);
    check("active", 24'h0123, active_ratio_q);
    frame(8, 24'h20);
    check("det", 24'h0f, det_q);
    ref_leads <= 1'b1;
    settle();
    check("det", 24'h0a, det_q);
    frame(8, 24'ha0);
    check("det", 24'h0c, det_q);
    frame(8, 24'h60);
    check("det", 24'h13, det_q[5:1]);
    frame(8, 24'he0);
    check("det", 24'h0b, det_q[5:1]);
    frame(8, 24'h33);
    check("det", 24'h0f, det_q);
    check("run", 24'h0, {counters_run_q, bias_on_q});
    check("ref", 24'h0, {ref_feedback_on_q, ref_input_on_q});
    check("outs", 24'h3, {out_one_q, out_two_oe_n_q});
    check("kept cfg", 24'h33, cfg_q);
    check("kept a", 24'hc00000, a_word_q);
    check("kept active", 24'h0123, active_ratio_q);
    frame(8, 24'h23);
    check("run", 24'h3, {counters_run_q, bias_on_q});
    check("ref", 24'h3, {ref_feedback_on_q, ref_input_on_q});
    check("det", 24'h07, det_q[5:1]);
    @(posedge mclk);
    divided_vco_pulse <= 1'b1;
    @(posedge mclk);
    divided_vco_pulse <= 1'b0;
    #1;
    check("jam", 24'h3, {r_jam_load_q, det_init_q});
    @(posedge mclk);
    #1;
    check("jam end", 24'h0, {r_jam_load_q, det_init_q});
    settle();
    check("det", 24'h0a, det_q);
    report_and_stop();
  end
endmodule

// [verilog/synth_cfg_pkg.sv]
// Constants, field layouts and carrier types for the synthesizer control block.
// Assumes a single reference clock domain plus the serial link clock.
package synth_cfg_pkg;
  localparam int CFG_W = 8;
  localparam int RATIO_W = 13;
  localparam int REF_W = 16;
  localparam int A_W = 24;
  localparam int CNT_W = 5;

  // Configuration byte field positions.
  localparam int POL_BIT = 7;
  localparam int SEL_BIT = 6;
  localparam int LDE_BIT = 5;
  localparam int HOLD_BIT = 4;
  localparam int CUR_HI_BIT = 3;
  localparam int CUR_LO_BIT = 2;
  localparam int PORT_BIT = 1;
  localparam int OUTB_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Reference ratio word layout.
  localparam int REF_MODE_LSB = 13;
  localparam int REF_MODE_MSB = 15;
  localparam logic [2:0] REF_STOP = 3'h0;
  localparam logic [2:0] REF_XTAL = 3'h1;
  localparam logic [2:0] REF_OFF = 3'h2;
  localparam logic [2:0] REF_DIV1 = 3'h3;
  localparam logic [2:0] REF_DIV8 = 3'h4;
  localparam logic [2:0] REF_DIV16 = 3'h7;
  localparam logic [12:0] RATIO_RESET = 13'h0000;

  // Output-one mode field in the A word.
  localparam int OUT_MODE_LSB = 22;
  localparam int OUT_MODE_MSB = 23;
  localparam logic [1:0] OUT_DATA = 2'h0;
  localparam logic [1:0] OUT_PORT = 2'h3;
  localparam logic [23:0] A_RESET = 24'h000000;

  // Frame lengths in serial clocks.
  localparam logic [4:0] FRAME_LOAD = 5'h00;
  localparam logic [4:0] FRAME_CFG = 5'h08;
  localparam logic [4:0] FRAME_REF = 5'h10;
  localparam logic [4:0] FRAME_A = 5'h18;

  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_FINE [4] = '{7'h46, 7'h50, 7'h5a, 7'h64};
  localparam logic [6:0] PCT_COARSE [4] = '{7'h19, 7'h32, 7'h4b, 7'h64};

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_RESUME = 3'b100
  } hold_state_t;

  typedef struct packed {
    logic pd_source;
    logic pd_sink;
    logic pd_oe_n;
    logic phi_r;
    logic phi_v;
    logic lock;
  } det_out_t;

  localparam det_out_t DET_RESET = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
endpackage

// [verilog/synth_config_standby_ctrl.sv]
// Control state of the synthesizer: serial register loads, standby sequencing and
// conditioning of the detector, lock and general outputs.
// Assumes the counters, detector core and prescaler run on mclk and the serial
// clock stops outside frames; frame_enable_n frames each access.
//
// Contract
// - Fine steps: current codes 0..3 give 70, 80, 90, 100 percent.
// - Coarse steps outside port mode: codes 0..3 give 25, 50, 75, 100 percent.
// - Prescaler divides by 65 with modulus control low, 64 when high.
// - Polarity bit inverts single-ended output and swaps double-ended outputs; resets low.
// - Select high enables single-ended and parks double-ended high; low does the reverse.
// - Lock indicator works only with lock-enable set, else held low; resets low.
// - Standby floats single-ended, parks double-ended high, stops counters and bias.
// - In standby the lock indicator follows the lock-enable bit statically.
// - Standby leaves A, reference and configuration registers untouched.
// - Static-low reference mode in standby cuts feedback resistor and reference input.
// - Leaving standby enables counters and bias but keeps pulses off detectors.
// - First VCO pulse after standby jam-loads R, resets detectors, reopens them.
// - In port mode general output one follows the port bit.
// - Port mode forces fine steps; otherwise port bit picks fine or coarse.
// - Standby never changes the port bit, open-drain bit, or their outputs.
// - Open-drain bit high floats general output two, low pulls it low.
// - An eight-clock frame loads only the configuration byte.
// - After power on general output one is in serial data-out mode.
// - A 24-clock frame loads A and copies first ratio buffer to second.
// - A 16-clock frame sets reference mode and fills only the first buffer.
// - A clockless enable pulse copies the first ratio buffer to the second.
// - Low 13 bits set the R ratio; high three bits drive reference divider.
// - Reference mode codes as listed; power up selects divide by eight.
// - Lock indicator is the AND of the two raw double-ended signals, even while select parks those outputs high.
`timescale 1ns/10ps
module synth_config_standby_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic frame_enable_n,
  input wire logic serial_in,
  input wire logic divided_vco_pulse,
  input wire logic vco_leads,
  input wire logic ref_leads,
  input wire logic modulus_ctrl,
  output synth_cfg_pkg::det_out_t det_q,
  output logic [7:0] cfg_q,
  output logic [2:0] ref_mode_q,
  output logic [12:0] active_ratio_q,
  output logic [12:0] pending_ratio_q,
  output logic [23:0] a_word_q,
  output logic [1:0] out_one_mode_q,
  output logic out_one_q,
  output logic out_two_q,
  output logic out_two_oe_n_q,
  output logic [6:0] current_pct_q,
  output logic counters_run_q,
  output logic bias_on_q,
  output logic ref_feedback_on_q,
  output logic ref_input_on_q,
  output logic r_jam_load_q,
  output logic det_init_q,
  output logic prescale_div65_q
);
  // Link side: a free-running clock count and the last 24 bits shifted in.
  // Nothing is cleared per frame, so no edge after the frame is ever needed.
  logic [4:0] lcnt_q;
  logic [23:0] lshift_q;

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      lcnt_q <= 5'h00;
      lshift_q <= 24'h000000;
    end else if (!frame_enable_n) begin
      lcnt_q <= lcnt_q + 5'h01;
      lshift_q <= {lshift_q[22:0], serial_in};
    end
  end

  // Frame end is taken from the synchronised enable; by then the serial clock
  // is idle, so the link count and shift word are stable to sample.
  logic [2:0] en_sync_q;
  logic [4:0] cnt_seen_q;
  logic frame_end;
  logic [4:0] nbits;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_sync_q <= 3'h7;
    end else begin
      en_sync_q <= {en_sync_q[1:0], frame_enable_n};
    end
  end

  assign frame_end = en_sync_q[1] & ~en_sync_q[2];
  assign nbits = lcnt_q - cnt_seen_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_seen_q <= 5'h00;
    end else if (frame_end) begin
      cnt_seen_q <= lcnt_q;
    end
  end

  // Register file. Standby has no path into any of these registers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= synth_cfg_pkg::CFG_RESET;
      ref_mode_q <= synth_cfg_pkg::REF_DIV8;
      pending_ratio_q <= synth_cfg_pkg::RATIO_RESET;
      active_ratio_q <= synth_cfg_pkg::RATIO_RESET;
      a_word_q <= synth_cfg_pkg::A_RESET;
    end else if (frame_end) begin
      case (nbits)
        synth_cfg_pkg::FRAME_CFG: begin
          cfg_q <= lshift_q[7:0];
        end
        synth_cfg_pkg::FRAME_REF: begin
          ref_mode_q <= lshift_q[synth_cfg_pkg::REF_MODE_MSB:synth_cfg_pkg::REF_MODE_LSB];
          pending_ratio_q <= lshift_q[12:0];
        end
        synth_cfg_pkg::FRAME_A: begin
          a_word_q <= lshift_q;
          active_ratio_q <= pending_ratio_q;
        end
        synth_cfg_pkg::FRAME_LOAD: begin
          active_ratio_q <= pending_ratio_q;
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  logic hold;
  logic port_mode;
  assign hold = cfg_q[synth_cfg_pkg::HOLD_BIT];
  assign port_mode = a_word_q[synth_cfg_pkg::OUT_MODE_MSB:synth_cfg_pkg::OUT_MODE_LSB]
    == synth_cfg_pkg::OUT_PORT;

  // Standby sequencer. Recovery waits for a VCO pulse so that the first
  // compare after standby starts from aligned counters, which keeps lock times
  // consistent.
  synth_cfg_pkg::hold_state_t state_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= synth_cfg_pkg::ST_RUN;
    end else begin
      case (state_q)
        synth_cfg_pkg::ST_RUN: begin
          if (hold) begin
            state_q <= synth_cfg_pkg::ST_HOLD;
          end
        end
        synth_cfg_pkg::ST_HOLD: begin
          if (!hold) begin
            state_q <= synth_cfg_pkg::ST_RESUME;
          end
        end
        synth_cfg_pkg::ST_RESUME: begin
          if (hold) begin
            state_q <= synth_cfg_pkg::ST_HOLD;
          end else if (divided_vco_pulse) begin
            state_q <= synth_cfg_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= synth_cfg_pkg::ST_HOLD;
        end
      endcase
    end
  end

  logic resume_hit;
  assign resume_hit = state_q == synth_cfg_pkg::ST_RESUME && !hold && divided_vco_pulse;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_jam_load_q <= 1'b0;
      det_init_q <= 1'b0;
    end else begin
      r_jam_load_q <= resume_hit;
      det_init_q <= resume_hit;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      counters_run_q <= 1'b1;
      bias_on_q <= 1'b1;
      ref_feedback_on_q <= 1'b1;
      ref_input_on_q <= 1'b1;
    end else begin
      counters_run_q <= !hold;
      bias_on_q <= !hold;
      ref_feedback_on_q <= !(hold && ref_mode_q == synth_cfg_pkg::REF_OFF);
      ref_input_on_q <= !(hold && ref_mode_q == synth_cfg_pkg::REF_OFF);
    end
  end

  // Detector conditioning. Raw lead indications are gated off until the
  // sequencer is back in the running state.
  logic gate;
  logic vl;
  logic rl;
  logic phi_v_raw;
  logic phi_r_raw;
  logic en_se;
  logic en_de;
  logic lead_sink;
  logic lead_src;
  logic detector_polarity_invert;

  assign gate = state_q == synth_cfg_pkg::ST_RUN && !hold;
  assign vl = gate & vco_leads;
  assign rl = gate & ref_leads;
  assign detector_polarity_invert = cfg_q[synth_cfg_pkg::POL_BIT];
  assign phi_v_raw = ~(detector_polarity_invert ? rl : vl);
  assign phi_r_raw = ~(detector_polarity_invert ? vl : rl);
  assign lead_sink = detector_polarity_invert ? rl : vl;
  assign lead_src = detector_polarity_invert ? vl : rl;
  assign en_se = cfg_q[synth_cfg_pkg::SEL_BIT] && !hold;
  assign en_de = !cfg_q[synth_cfg_pkg::SEL_BIT] && !hold;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      det_q <= synth_cfg_pkg::DET_RESET;
    end else begin
      det_q.pd_source <= en_se & lead_src;
      det_q.pd_sink <= en_se & lead_sink;
      det_q.pd_oe_n <= !(en_se && (lead_src || lead_sink));
      det_q.phi_v <= en_de ? phi_v_raw : 1'b1;
      det_q.phi_r <= en_de ? phi_r_raw : 1'b1;
      if (!cfg_q[synth_cfg_pkg::LDE_BIT]) begin
        det_q.lock <= 1'b0;
      end else if (hold) begin
        det_q.lock <= 1'b1;
      end else begin
        det_q.lock <= phi_r_raw & phi_v_raw;
      end
    end
  end

  // General outputs and current code. None of this looks at standby.
  logic [1:0] cur_code;
  assign cur_code = cfg_q[synth_cfg_pkg::CUR_HI_BIT:synth_cfg_pkg::CUR_LO_BIT];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_one_mode_q <= synth_cfg_pkg::OUT_DATA;
      out_one_q <= 1'b0;
      out_two_q <= 1'b0;
      out_two_oe_n_q <= 1'b0;
      current_pct_q <= synth_cfg_pkg::PCT_FULL;
      prescale_div65_q <= 1'b1;
    end else begin
      out_one_mode_q <= a_word_q[synth_cfg_pkg::OUT_MODE_MSB:synth_cfg_pkg::OUT_MODE_LSB];
      out_one_q <= port_mode & cfg_q[synth_cfg_pkg::PORT_BIT];
      out_two_q <= 1'b0;
      out_two_oe_n_q <= cfg_q[synth_cfg_pkg::OUTB_BIT];
      if (!port_mode && cfg_q[synth_cfg_pkg::PORT_BIT]) begin
        current_pct_q <= synth_cfg_pkg::PCT_COARSE[cur_code];
      end else begin
        current_pct_q <= synth_cfg_pkg::PCT_FINE[cur_code];
      end
      prescale_div65_q <= !modulus_ctrl;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_frame(logic [4:0] n);
    frame_end && nbits == n;
  endsequence

  sequence s_release;
    state_q == synth_cfg_pkg::ST_HOLD && !hold;
  endsequence

  sequence s_reopen;
    r_jam_load_q && det_init_q && state_q == synth_cfg_pkg::ST_RUN;
  endsequence

  property p_cfg_only;
    s_frame(synth_cfg_pkg::FRAME_CFG) |=> cfg_q == $past(lshift_q[7:0])
      && $stable(a_word_q) && $stable(pending_ratio_q) && $stable(active_ratio_q);
  endproperty
  a_cfg_only: assert property (p_cfg_only) else $error("config frame misloaded");

  property p_ref_buf1;
    s_frame(synth_cfg_pkg::FRAME_REF) |=> $stable(active_ratio_q)
      && pending_ratio_q == $past(lshift_q[12:0]) && $stable(cfg_q);
  endproperty
  a_ref_buf1: assert property (p_ref_buf1) else $error("ratio frame misloaded");

  property p_a_copy;
    s_frame(synth_cfg_pkg::FRAME_A) |=> active_ratio_q == $past(pending_ratio_q);
  endproperty
  a_a_copy: assert property (p_a_copy) else $error("A frame did not copy ratio");

  property p_hold_park;
    hold |=> det_q.phi_r && det_q.phi_v && det_q.pd_oe_n && !counters_run_q && !bias_on_q;
  endproperty
  a_hold_park: assert property (p_hold_park) else $error("standby outputs wrong");

  property p_lock_off;
    !cfg_q[synth_cfg_pkg::LDE_BIT] |=> !det_q.lock;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock not held low");

  property p_release;
    s_release ##1 (!hold && !divided_vco_pulse) |=> counters_run_q && bias_on_q
      && state_q == synth_cfg_pkg::ST_RESUME && det_q.phi_r && det_q.phi_v;
  endproperty
  a_release: assert property (p_release) else $error("standby exit step one wrong");

  property p_reopen;
    resume_hit |=> s_reopen;
  endproperty
  a_reopen: assert property (p_reopen) else $error("jam load missing");

  property p_outb;
    ##1 1'b1 |-> out_two_oe_n_q == $past(cfg_q[synth_cfg_pkg::OUTB_BIT]);
  endproperty
  a_outb: assert property (p_outb) else $error("output two wrong");

  property p_port_fine;
    port_mode |=> current_pct_q == synth_cfg_pkg::PCT_FINE[$past(cur_code)];
  endproperty
  a_port_fine: assert property (p_port_fine) else $error("port mode not fine steps");

  property p_prescale;
    modulus_ctrl |=> !prescale_div65_q;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale ratio wrong");

  property p_hold_keep;
    hold && !frame_end |=> $stable(cfg_q) && $stable(a_word_q) && $stable(ref_mode_q)
      && $stable(pending_ratio_q) && $stable(active_ratio_q);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("standby changed a register");

  property p_hold_lock;
    hold && cfg_q[synth_cfg_pkg::LDE_BIT] |=> det_q.lock;
  endproperty
  a_hold_lock: assert property (p_hold_lock) else $error("standby lock level wrong");
endmodule
